// ### hdl/nvs_pkg.sv
// nvs_pkg: shared constants of the serial nonvolatile RAM port
package nvs_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int WORDS     = 16;
    localparam int WORD_W    = 16;
    localparam int ADDR_W    = 4;
    localparam int INSTR_W   = 8;
    localparam int OP_W      = 3;
    localparam int CNT_W     = 4;
    localparam int POS_W     = 5;
    localparam int TIMER_W   = 20;

    localparam logic [CNT_W-1:0] CNT_READ_DECIDE = 4'h6;
    localparam logic [CNT_W-1:0] CNT_LAST_INSTR  = 4'h7;
    localparam logic [CNT_W-1:0] CNT_INSTR_FULL  = 4'h8;
    localparam logic [POS_W-1:0] READ_BITS       = 5'h10;

    // instruction fields
    localparam int INSTR_START_BIT = 7;
    localparam int ADDR_HI         = 6;
    localparam int ADDR_LO         = 3;

    // ------------------------------------------------------------------
    // operation codes (low three instruction bits)
    // ------------------------------------------------------------------
    localparam logic [OP_W-1:0] WRITE_DISABLE_CMD = 3'h0;
    localparam logic [OP_W-1:0] STORE_CMD         = 3'h1;
    localparam logic [OP_W-1:0] RESERVED_CMD      = 3'h2;
    localparam logic [OP_W-1:0] WRITE_CMD         = 3'h3;
    localparam logic [OP_W-1:0] WRITE_ENABLE_CMD  = 3'h4;
    localparam logic [OP_W-1:0] RECALL_CMD        = 3'h5;
    localparam logic [1:0]      READ_CMD_HI       = 2'h3;

    localparam logic [WORD_W-1:0] NV_INIT = 16'h0000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint CLK_PERIOD_PS  = 8000;
    localparam longint PS_PER_MS      = 1000000000;
    localparam longint PS_PER_US      = 1000000;
    localparam longint STORE_TIME_MS  = 5;
    localparam longint RECALL_TIME_US = 2;
    localparam int STORE_CYCLES  =
        int'((STORE_TIME_MS * PS_PER_MS) / CLK_PERIOD_PS);
    localparam int RECALL_CYCLES =
        int'((RECALL_TIME_US * PS_PER_US) / CLK_PERIOD_PS);

    // host link clock: half period in mclk cycles, deselect gap
    localparam int HALF_DIV     = 6;
    localparam int DESEL_CYCLES = 16;
    localparam int DIV_W        = 4;
    localparam int EDGE_W       = 5;
    localparam logic [EDGE_W-1:0] EDGES_SHORT = 5'h08;
    localparam logic [EDGE_W-1:0] EDGES_LONG  = 5'h18;

endpackage : nvs_pkg

// ### hdl/nvs_link_if.sv
// nvs_link_if: pins between host and nonvolatile RAM device
interface nvs_link_if;
    logic chipEnable;   // high selects the device
    logic serialClk;    // link clock made by the host
    logic serialIn;     // host to device data
    logic serialOut;    // device to host data
    logic serialOutEn;  // device drives serialOut
    logic storeN;       // hardware store request, low active
    logic recallN;      // hardware recall request, low active

    modport dev (
        input  chipEnable,
        input  serialClk,
        input  serialIn,
        input  storeN,
        input  recallN,
        output serialOut,
        output serialOutEn
    );

    modport host (
        output chipEnable,
        output serialClk,
        output serialIn,
        output storeN,
        output recallN,
        input  serialOut,
        input  serialOutEn
    );
endinterface : nvs_link_if

// ### hdl/nvs_sync.sv
// nvs_sync: two flip-flop synchroniser for a vector of levels
module nvs_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,   // destination clock
    input  wire logic [W-1:0] async,  // levels from another domain
    output logic      [W-1:0] sync    // synchronised levels
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge mclk) begin
        meta_reg <= async;
        sync     <= meta_reg;
    end
endmodule : nvs_sync

// ### hdl/nvs_device.sv
// nvs_device: serial command port and control of the 16x16 nv RAM
// Function
// - 8-bit instruction register, shifted in MSB first
// - bit 7 one, address bits 6..3, op 2..0
// - leading zeros ignored until start one
// - enable low clears instruction, enters standby
// - host holds enable high, drops after operation
// - static serial clock, stopping holds all state
// - data output driven only during read data
// - recall command or pin copies, sets recall latch
// - power-up recall leaves recall latch clear
// - write-enable latch gates writes and stores
// - store needs request plus both latches set
// - store blocks all, then clears write enable
// - store within 5 ms, recall 2 us
// - write: address in instruction, 16 data bits
// - early deselect still writes shifted bits
// - past 24 clocks keep shifting, overwrite
// - read: first bit on eighth falling edge
// - opcode decode of the low three bits
// - old power-down instruction accepted, ignored
// - commands ignored during power-up recall
module nvs_device #(
    parameter int STORE_CYCLES  = nvs_pkg::STORE_CYCLES,
    parameter int RECALL_CYCLES = nvs_pkg::RECALL_CYCLES
) (
    input  wire logic mclk,            // core clock, 125 MHz
    input  wire logic reset_n,         // sync reset, models power-up
    nvs_link_if.dev   link,            // pins to the host
    output logic      storeBusy,       // store cycle in progress
    output logic      writeEnLatch,    // write-enable latch
    output logic      prevRecallLatch  // previous-recall latch
);
    typedef enum logic [1:0] {
        PWRUP, IDLE, STORING, RECALLING
    } nvs_core_t;

    // ------------------------------------------------------------------
    // link domain: instruction and data shifting
    // ------------------------------------------------------------------
    logic [nvs_pkg::CNT_W-1:0]   bitCnt_reg;
    logic [nvs_pkg::INSTR_W-1:0] instr_reg;
    logic                        isWrite_reg;
    logic                        wrArm_reg;
    logic                        rdReq_reg;
    logic                        cmdReq_reg;
    logic [nvs_pkg::POS_W-1:0]   rdPos_reg;
    logic                        outLoaded_reg;
    logic [nvs_pkg::ADDR_W-1:0]  wrAddr_reg;
    logic [nvs_pkg::ADDR_W-1:0]  rdAddr_reg;
    logic [nvs_pkg::WORD_W-1:0]  wrData_reg;
    logic [nvs_pkg::OP_W-1:0]    cmdOp_reg;
    logic [nvs_pkg::WORD_W-1:0]  outWord_reg;
    logic [nvs_pkg::WORD_W-1:0]  readWord_reg;

    wire [nvs_pkg::INSTR_W-1:0] instrNext =
        {instr_reg[nvs_pkg::INSTR_W-2:0], link.serialIn};
    wire started    = bitCnt_reg != '0;
    wire shiftInstr = (started || link.serialIn)
                      && bitCnt_reg < nvs_pkg::CNT_INSTR_FULL;
    wire readSeen   = bitCnt_reg == nvs_pkg::CNT_READ_DECIDE
                      && {instr_reg[0], link.serialIn}
                         == nvs_pkg::READ_CMD_HI;
    wire instrDone  = bitCnt_reg == nvs_pkg::CNT_LAST_INSTR;
    wire [nvs_pkg::OP_W-1:0] opNext = instrNext[nvs_pkg::OP_W-1:0];
    wire opIsWrite  = opNext == nvs_pkg::WRITE_CMD;
    // reserved and read codes raise no command request
    wire opIsCmd    = opNext == nvs_pkg::WRITE_DISABLE_CMD
                      || opNext == nvs_pkg::STORE_CMD
                      || opNext == nvs_pkg::WRITE_ENABLE_CMD
                      || opNext == nvs_pkg::RECALL_CMD;
    wire instrFull  = bitCnt_reg == nvs_pkg::CNT_INSTR_FULL;
    wire dataBit    = isWrite_reg && instrFull;
    wire readShift  = outLoaded_reg && rdPos_reg < nvs_pkg::READ_BITS;

    // enable low acts as the asynchronous clear of the frame state
    always_ff @(posedge link.serialClk or negedge link.chipEnable) begin
        if (!link.chipEnable) begin
            bitCnt_reg  <= '0;
            instr_reg   <= '0;
            isWrite_reg <= 1'b0;
            wrArm_reg   <= 1'b0;
            rdReq_reg   <= 1'b0;
            cmdReq_reg  <= 1'b0;
            rdPos_reg   <= '0;
        end else begin
            if (shiftInstr) begin
                instr_reg  <= instrNext;
                bitCnt_reg <= bitCnt_reg + 1'b1;
            end
            if (readSeen)
                rdReq_reg <= 1'b1;
            if (instrDone) begin
                isWrite_reg <= opIsWrite;
                cmdReq_reg  <= opIsCmd;
            end
            if (dataBit)
                wrArm_reg <= 1'b1;
            if (readShift)
                rdPos_reg <= rdPos_reg + 1'b1;
        end
    end

    // datapath kept across deselect so the core can commit a write
    always_ff @(posedge link.serialClk) begin
        if (readSeen)
            rdAddr_reg <= instr_reg[nvs_pkg::ADDR_W:1];
        if (instrDone) begin
            wrAddr_reg <= instrNext[nvs_pkg::ADDR_HI:nvs_pkg::ADDR_LO];
            cmdOp_reg  <= opNext;
            wrData_reg <= '0;
        end else if (dataBit) begin
            // shifting never stops, so bits past 24 clocks overwrite
            wrData_reg <= {wrData_reg[nvs_pkg::WORD_W-2:0],
                           link.serialIn};
        end
    end

    // first read bit leaves on the falling edge of the eighth clock
    always_ff @(negedge link.serialClk or negedge link.chipEnable) begin
        if (!link.chipEnable)
            outLoaded_reg <= 1'b0;
        else if (rdReq_reg && instrFull)
            outLoaded_reg <= 1'b1;
    end

    // readWord is quiet by then: loaded well before this edge
    always_ff @(negedge link.serialClk) begin
        if (rdReq_reg && instrFull && !outLoaded_reg)
            outWord_reg <= readWord_reg;
    end

    wire [nvs_pkg::ADDR_W-1:0] outIdx = ~rdPos_reg[nvs_pkg::ADDR_W-1:0];
    assign link.serialOut   = outWord_reg[outIdx];
    assign link.serialOutEn = link.chipEnable && readShift;

    // ------------------------------------------------------------------
    // core domain: crossings
    // ------------------------------------------------------------------
    logic ceS, rdS, cmdS, armS, storeNS, recallNS;
    logic cePrev_reg, rdPrev_reg, cmdPrev_reg, wrPend_reg;

    nvs_sync #(.W(6)) u_sync (
        .mclk  (mclk),
        .async ({link.chipEnable, rdReq_reg, cmdReq_reg, wrArm_reg,
                 link.storeN, link.recallN}),
        .sync  ({ceS, rdS, cmdS, armS, storeNS, recallNS})
    );

    wire ceFall = cePrev_reg && !ceS;
    wire rdEv   = rdS && !rdPrev_reg;
    wire cmdEv  = cmdS && !cmdPrev_reg;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cePrev_reg  <= 1'b0;
            rdPrev_reg  <= 1'b0;
            cmdPrev_reg <= 1'b0;
            wrPend_reg  <= 1'b0;
        end else begin
            cePrev_reg  <= ceS;
            rdPrev_reg  <= rdS;
            cmdPrev_reg <= cmdS;
            if (ceFall)
                wrPend_reg <= 1'b0;
            else if (ceS && armS)
                wrPend_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // core domain: latches, store and recall sequencing
    // ------------------------------------------------------------------
    nvs_core_t                  state_reg;
    logic [nvs_pkg::TIMER_W-1:0] timer_reg;
    logic                       wel_reg;
    logic                       prl_reg;
    logic [nvs_pkg::WORD_W-1:0] ram_reg [nvs_pkg::WORDS];
    logic [nvs_pkg::WORD_W-1:0] nv_reg  [nvs_pkg::WORDS];

    wire idle      = state_reg == IDLE;
    wire timerDone = timer_reg == '0;
    wire cmdRecall = cmdEv && cmdOp_reg == nvs_pkg::RECALL_CMD;
    wire cmdStore  = cmdEv && cmdOp_reg == nvs_pkg::STORE_CMD;
    wire startRecall = idle && (!recallNS || cmdRecall);
    wire startStore  = idle && !startRecall
                       && (!storeNS || cmdStore)
                       && wel_reg && prl_reg;
    wire pwrupCopy   = state_reg == PWRUP && timerDone;
    wire copyNv      = startRecall || pwrupCopy;
    wire doWrite     = idle && ceFall && wrPend_reg
                       && wel_reg;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= PWRUP;
            timer_reg <= nvs_pkg::TIMER_W'(RECALL_CYCLES - 1);
            wel_reg   <= 1'b0;
            prl_reg   <= 1'b0;
        end else begin
            if (!timerDone)
                timer_reg <= timer_reg - 1'b1;
            unique case (state_reg)
                PWRUP: begin
                    if (timerDone)
                        state_reg <= IDLE;
                end
                IDLE: begin
                    if (startRecall) begin
                        state_reg <= RECALLING;
                        timer_reg <= nvs_pkg::TIMER_W'(RECALL_CYCLES - 1);
                        prl_reg   <= 1'b1;
                    end else if (startStore) begin
                        state_reg <= STORING;
                        timer_reg <= nvs_pkg::TIMER_W'(STORE_CYCLES - 1);
                    end
                    // power-down code matches neither branch: no action
                    if (cmdEv && cmdOp_reg
                        == nvs_pkg::WRITE_ENABLE_CMD)
                        wel_reg <= 1'b1;
                    else if (cmdEv && cmdOp_reg
                             == nvs_pkg::WRITE_DISABLE_CMD)
                        wel_reg <= 1'b0;
                end
                STORING: begin
                    if (timerDone) begin
                        state_reg <= IDLE;
                        wel_reg   <= 1'b0;
                    end
                end
                RECALLING: begin
                    if (timerDone)
                        state_reg <= IDLE;
                end
            endcase
        end
    end

    // read word fetched when the seventh bit marks a read
    always_ff @(posedge mclk) begin
        if (!reset_n)
            readWord_reg <= nvs_pkg::NV_INIT;
        else if (rdEv && idle)
            readWord_reg <= ram_reg[rdAddr_reg];
    end

    for (genvar i = 0; i < nvs_pkg::WORDS; i++) begin : g_word
        wire hit = doWrite && wrAddr_reg == nvs_pkg::ADDR_W'(i);
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                ram_reg[i] <= nvs_pkg::NV_INIT;
                nv_reg[i]  <= nvs_pkg::NV_INIT;
            end else begin
                if (copyNv)
                    ram_reg[i] <= nv_reg[i];
                else if (hit)
                    ram_reg[i] <= wrData_reg;
                if (startStore)
                    nv_reg[i] <= ram_reg[i];
            end
        end
    end

    assign storeBusy       = state_reg == STORING;
    assign writeEnLatch    = wel_reg;
    assign prevRecallLatch = prl_reg;
endmodule : nvs_device

// ### hdl/nvs_host.sv
// nvs_host: host end that frames commands onto the serial link
module nvs_host (
    input  wire logic        mclk,      // host clock, 125 MHz
    input  wire logic        reset_n,   // sync reset, low active
    nvs_link_if.host         link,      // pins to the device
    input  wire logic        reqValid,  // command request
    output logic             reqReady,  // host can take a command
    input  wire logic [2:0]  reqOp,     // operation code
    input  wire logic [3:0]  reqAddr,   // word address
    input  wire logic [15:0] reqData,   // write data
    output logic             rspValid,  // read data pulse
    output logic [15:0]      rspData,   // read data word
    input  wire logic        hwStore,   // drive store pin low
    input  wire logic        hwRecall   // drive recall pin low
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_SHIFT, H_DESEL} nvs_host_t;

    // ------------------------------------------------------------------
    // frame sequencer; the link clock is mclk divided down
    // ------------------------------------------------------------------
    localparam int TX_W = nvs_pkg::INSTR_W + nvs_pkg::WORD_W;

    nvs_host_t                    state_reg;
    logic [nvs_pkg::DIV_W-1:0]    div_reg;
    logic [nvs_pkg::EDGE_W-1:0]   edges_reg;
    logic [nvs_pkg::EDGE_W-1:0]   total_reg;
    logic                         isRead_reg;
    logic [TX_W-1:0]              tx_reg;
    logic [nvs_pkg::WORD_W-1:0]   rx_reg;
    logic                         sk_reg, ce_reg;
    logic                         stoN_reg, rclN_reg;
    logic                         soS;

    nvs_sync #(.W(1)) u_so (
        .mclk  (mclk),
        .async (link.serialOut),
        .sync  (soS)
    );

    wire phaseEnd = div_reg == nvs_pkg::DIV_W'(nvs_pkg::HALF_DIV - 1);
    wire reqIsRead  = reqOp[2:1] == nvs_pkg::READ_CMD_HI;
    wire reqIsLong  = reqIsRead || reqOp == nvs_pkg::WRITE_CMD;
    wire sampleBit  = isRead_reg && edges_reg >= nvs_pkg::EDGES_SHORT;
    wire frameEnd   = edges_reg == total_reg;

    assign reqReady = state_reg == H_IDLE;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg  <= H_IDLE;
            div_reg    <= '0;
            edges_reg  <= '0;
            total_reg  <= '0;
            isRead_reg <= 1'b0;
            tx_reg     <= '0;
            rx_reg     <= '0;
            sk_reg     <= 1'b0;
            ce_reg     <= 1'b0;
            rspValid   <= 1'b0;
            rspData    <= '0;
        end else begin
            rspValid <= 1'b0;
            div_reg  <= phaseEnd ? '0 : div_reg + 1'b1;
            unique case (state_reg)
                H_IDLE: begin
                    div_reg <= '0;
                    if (reqValid) begin
                        state_reg  <= H_SETUP;
                        ce_reg     <= 1'b1;
                        edges_reg  <= '0;
                        isRead_reg <= reqIsRead;
                        total_reg  <= reqIsLong ? nvs_pkg::EDGES_LONG
                                                : nvs_pkg::EDGES_SHORT;
                        tx_reg     <= {1'b1, reqAddr, reqOp, reqData};
                    end
                end
                H_SETUP: begin
                    if (phaseEnd)
                        state_reg <= H_SHIFT;
                end
                H_SHIFT: begin
                    if (phaseEnd && sk_reg) begin
                        sk_reg <= 1'b0;
                        tx_reg <= {tx_reg[TX_W-2:0], 1'b0};
                    end else if (phaseEnd && frameEnd) begin
                        // deselect before another rising edge
                        ce_reg    <= 1'b0;
                        state_reg <= H_DESEL;
                        rspValid  <= isRead_reg;
                        rspData   <= rx_reg;
                    end else if (phaseEnd) begin
                        if (sampleBit)
                            rx_reg <= {rx_reg[nvs_pkg::WORD_W-2:0], soS};
                        sk_reg    <= 1'b1;
                        edges_reg <= edges_reg + 1'b1;
                    end
                end
                H_DESEL: begin
                    if (div_reg == nvs_pkg::DIV_W'(nvs_pkg::HALF_DIV - 1)
                        && edges_reg == '0)
                        state_reg <= H_IDLE;
                    else if (phaseEnd)
                        edges_reg <= '0;
                end
            endcase
        end
    end

    // hardware request pins are plain levels, held as registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stoN_reg <= 1'b1;
            rclN_reg <= 1'b1;
        end else begin
            stoN_reg <= !hwStore;
            rclN_reg <= !hwRecall;
        end
    end

    assign link.chipEnable = ce_reg;
    assign link.serialClk  = sk_reg;
    assign link.serialIn   = tx_reg[TX_W-1];
    assign link.storeN     = stoN_reg;
    assign link.recallN    = rclN_reg;
endmodule : nvs_host

// ### hdl/nvs_unused_note.sv
// nvs_unused_note: empty file, holds no logic

// ### sim/nvs_properties.sv
// nvs_properties: checks on the host-device link, the latches and store timing
module nvs_properties #(
    parameter int STORE_CYCLES = 100
) (
    input wire logic mclk,           // core clock
    input wire logic reset_n,        // sync reset
    input wire logic chipEnable,     // link select
    input wire logic serialClk,      // link clock
    input wire logic serialOutEn,    // device drives data out
    input wire logic recallN,        // recall pin
    input wire logic storeBusy,      // store running
    input wire logic writeEnLatch,   // write-enable latch
    input wire logic prevRecallLatch // previous-recall latch
);
    timeunit 1ns;
    timeprecision 100ps;
    // busy counter: a repetition this long would not unroll
    int busyCnt;
    always_ff @(posedge mclk) begin
        if (!reset_n || !storeBusy) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= busyCnt + 1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_rd_start;
        $rose(serialOutEn);
    endsequence
    sequence s_rd_word;
        (serialOutEn && chipEnable) [*8];
    endsequence
    property p_out_ce; $rose(chipEnable) |-> !serialOutEn [*8]; endproperty
    a_out_ce: assert property (p_out_ce) else $error("out on, idle");
    property p_pwr;
        $rose(reset_n) |-> !writeEnLatch && !prevRecallLatch && !storeBusy;
    endproperty
    a_pwr: assert property (p_pwr) else $error("latch set at power-up");
    property p_sto_cond;
        $rose(storeBusy) |-> writeEnLatch && prevRecallLatch;
    endproperty
    a_sto_cond: assert property (p_sto_cond) else $error("bad store");
    property p_sto_end; $fell(storeBusy) |-> ##[0:2] !writeEnLatch; endproperty
    a_sto_end: assert property (p_sto_end) else $error("latch kept");
    property p_sto_len; busyCnt <= STORE_CYCLES; endproperty
    a_sto_len: assert property (p_sto_len) else $error("store long");
    property p_wen_rise; $rose(writeEnLatch) |-> chipEnable; endproperty
    a_wen_rise: assert property (p_wen_rise) else $error("wen set");
    property p_rd_edge; s_rd_start |-> !serialClk; endproperty
    a_rd_edge: assert property (p_rd_edge) else $error("first bit edge");
    property p_rd_hold; s_rd_start |-> s_rd_word; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read short");
    property p_hw_rcl;
        $fell(recallN) && !storeBusy |-> ##[1:8] prevRecallLatch;
    endproperty
    a_hw_rcl: assert property (p_hw_rcl) else $error("pin recall");
endmodule : nvs_properties

// ### sim/test_serial_nv_sram_command_port.sv
// test_serial_nv_sram_command_port: host end driving device end
module test_serial_nv_sram_command_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STORE_N = 100; // short store keeps the run brief
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        reqValid = 1'b0;
    logic [2:0]  reqOp = 3'h0;
    logic [3:0]  reqAddr = 4'h0;
    logic [15:0] reqData = 16'h0000;
    logic        hwStore = 1'b0;
    logic        hwRecall = 1'b0;
    logic        reqReady, rspValid, storeBusy, writeEnLatch, prevRecallLatch;
    logic [15:0] rspData, rdWord;
    int          n_mismatch = 0;
    int          tests_run = 0;
    nvs_link_if link ();
    nvs_host u_nvs_host (.mclk(mclk), .reset_n(reset_n), .link(link),
        .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
        .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
        .rspData(rspData), .hwStore(hwStore), .hwRecall(hwRecall));
    nvs_device #(.STORE_CYCLES(STORE_N), .RECALL_CYCLES(250)) u_nvs_device (
        .mclk(mclk), .reset_n(reset_n), .link(link), .storeBusy(storeBusy),
        .writeEnLatch(writeEnLatch), .prevRecallLatch(prevRecallLatch));
    nvs_properties #(.STORE_CYCLES(STORE_N)) u_nvs_properties (
        .mclk(mclk), .reset_n(reset_n), .chipEnable(link.chipEnable),
        .serialClk(link.serialClk), .serialOutEn(link.serialOutEn),
        .recallN(link.recallN), .storeBusy(storeBusy),
        .writeEnLatch(writeEnLatch), .prevRecallLatch(prevRecallLatch));
    always #4 mclk = ~mclk;
    task automatic close_out;
        $display("mismatches %0d compares %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_flag(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag
    task automatic send(input logic [2:0] op, input logic [3:0] a,
                        input logic [15:0] d);
        int n;
        @(negedge mclk);
        reqValid = 1'b1;
        reqOp = op;
        reqAddr = a;
        reqData = d;
        @(negedge mclk);
        reqValid = 1'b0;
        for (n = 0; n < 1000 && reqReady !== 1'b1; n++) begin
            @(negedge mclk);
            if (rspValid === 1'b1) rdWord = rspData;
        end
        if (n == 1000) begin
            n_mismatch++;
            close_out();
        end
        repeat (4) @(negedge mclk); // idle gap before the next request; a write has already committed during deselect
    endtask : send
    task automatic rd(input logic [2:0] op, input logic [3:0] a,
                      input logic [15:0] exp);
        rdWord = 16'hxxxx;
        send(op, a, 16'h0000);
        chk_word(rdWord, exp);
    endtask : rd
    task automatic wait_store;
        int n;
        for (n = 0; n < 500 && storeBusy !== 1'b0; n++) @(negedge mclk);
        if (n == 500) begin
            n_mismatch++;
            close_out();
        end
    endtask : wait_store
    task automatic pin(input logic st); // short low pulse on a pin
        hwStore = st;
        hwRecall = !st;
        repeat (4) @(negedge mclk);
        hwStore = 1'b0;
        hwRecall = 1'b0;
        repeat (8) @(negedge mclk);
    endtask : pin
    initial begin
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        send(3'h4, 4'h0, 16'h0000);
        chk_flag(writeEnLatch, 1'b0);
        repeat (250) @(negedge mclk);
        chk_flag(prevRecallLatch, 1'b0);
        send(3'h3, 4'h3, 16'h1234);
        rd(3'h6, 4'h3, 16'h0000);
        $display("test power-up done");
        send(3'h4, 4'h0, 16'h0000);
        chk_flag(writeEnLatch, 1'b1);
        for (int i = 0; i < 4; i++) begin
            send(3'h3, 4'(5 * i), 16'hA5C0 + 16'(i));
        end
        for (int i = 0; i < 4; i++) begin
            rd({2'h3, 1'(i)}, 4'(5 * i), 16'hA5C0 + 16'(i));
        end
        send(3'h2, 4'h5, 16'hFFFF);
        chk_flag(writeEnLatch, 1'b1);
        rd(3'h7, 4'h5, 16'hA5C1);
        send(3'h1, 4'h0, 16'h0000);
        chk_flag(storeBusy, 1'b0);
        send(3'h5, 4'h0, 16'h0000);
        repeat (260) @(negedge mclk);
        chk_flag(prevRecallLatch, 1'b1);
        rd(3'h6, 4'h5, 16'h0000);
        $display("test commands done");
        send(3'h3, 4'h5, 16'h5AC3);
        send(3'h1, 4'h0, 16'h0000);
        chk_flag(storeBusy, 1'b1);
        wait_store();
        chk_flag(writeEnLatch, 1'b0);
        send(3'h4, 4'h0, 16'h0000);
        send(3'h3, 4'h5, 16'h0F0F);
        pin(1'b0);
        repeat (260) @(negedge mclk);
        rd(3'h6, 4'h5, 16'h5AC3);
        send(3'h0, 4'h0, 16'h0000);
        chk_flag(writeEnLatch, 1'b0);
        send(3'h4, 4'h0, 16'h0000);
        pin(1'b1);
        chk_flag(storeBusy, 1'b1);
        wait_store();
        chk_flag(writeEnLatch, 1'b0);
        $display("test store and recall done");
        send(3'h4, 4'h0, 16'h0000);
        reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        repeat (260) @(negedge mclk);
        chk_flag(writeEnLatch, 1'b0);
        chk_flag(prevRecallLatch, 1'b0);
        pin(1'b0);
        chk_flag(prevRecallLatch, 1'b1);
        $display("test second power-up done");
        close_out();
    end
endmodule : test_serial_nv_sram_command_port
